// ==== pkg/srcp_defines.svh ====
// Constants of the serial register command port: rates, timing, command layout.
`ifndef SRCP_DEFINES_SVH
`define SRCP_DEFINES_SVH

// Core clock and the two line rates chosen by the strap
`define SRCP_CLK_HZ          200000000
`define SRCP_BAUD_SLOW       57600
`define SRCP_BAUD_FAST       115200

// Character framing: data bits per character, bit slots after the start bit
`define SRCP_DATA_BITS       8
`define SRCP_LAST_SLOT       4'h9

// Receive buffer depth in bytes
`define SRCP_FIFO_DEPTH      16

// Query register addresses
`define SRCP_ADDR_STATUS     8'h18
`define SRCP_ADDR_TEMP       8'h19
`define SRCP_ADDR_CAL_MEM    8'h20
`define SRCP_ADDR_USER_MEM   8'h22

// Data bytes that follow each address byte
`define SRCP_LEN_STATUS      3'h1
`define SRCP_LEN_TEMP        3'h1
`define SRCP_LEN_CAL_MEM     3'h2
`define SRCP_LEN_USER_MEM    3'h2
`define SRCP_LEN_CONFIG      3'h4

// Acknowledge byte values
`define SRCP_ACK_OK          8'h01
`define SRCP_ACK_FAIL        8'h00

// Strap is read once the edge counter after reset release reaches this value, on the third edge
`define SRCP_STRAP_TAKE      2'h2

`endif

// ==== pkg/srcp_pkg.sv ====
// Types shared by the serial register command port.
package srcp_pkg;

    // Command machine, Gray coded along address -> data -> execute -> answer
    typedef enum logic [1:0] {
        SRCP_ADDR = 2'b00,
        SRCP_DATA = 2'b01,
        SRCP_EXEC = 2'b11,
        SRCP_SEND = 2'b10
    } srcp_state_t;

endpackage

// ==== core/srcp_fifo.sv ====
// Byte FIFO between the serial receiver and the command machine.
`timescale 1ns/10ps
module srcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("srcp_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    // Pointers carry one extra bit so full and empty are told apart
    assign out_valid = (wr_ptr != rd_ptr);
    assign in_ready  = (wr_ptr != {~rd_ptr[AW], rd_ptr[AW-1:0]});
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= '0;
        end else if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_ptr <= '0;
        end else if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

endmodule // srcp_fifo

// ==== core/srcp_cmd_port.sv ====
// Serial register command port: asynchronous receiver, command machine, answer transmitter.
//
// What this block does
// - Strap high or open selects 57600 baud.
// - Strap low selects 115200 baud.
// - Strap read only after reset; rate held.
// - 8 data bits, no parity, one stop.
// - Collect all data bytes before acting.
// - One acknowledge byte after each configuration.
// - Acknowledge is 1 on success, 0 otherwise.
// - Every query answers with exactly two bytes.
// - Query answer goes high byte first.
// - Status and temperature: both bytes valid.
// - Memory reads: only low byte valid.
// - Temperature returned as raw code.
`timescale 1ns/10ps
`include "srcp_defines.svh"
module srcp_cmd_port #(
    parameter int FIFO_DEPTH = `SRCP_FIFO_DEPTH,
    // Core clock rating; both bit dividers are derived from it
    parameter int CLK_HZ     = `SRCP_CLK_HZ
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        serial_rx,
    output logic             serial_tx,
    input  wire logic        rate_strap,
    output logic             fast_rate,
    output logic             rx_overrun,
    output logic             cfg_req,
    output logic             qry_req,
    output logic [7:0]       cmd_addr,
    output logic [31:0]      cmd_data,
    input  wire logic        cfg_done,
    input  wire logic        cfg_ok,
    input  wire logic        qry_done,
    input  wire logic [15:0] qry_value
);
    localparam int DIV_SLOW_I = CLK_HZ / `SRCP_BAUD_SLOW;
    localparam int DIV_FAST_I = CLK_HZ / `SRCP_BAUD_FAST;
    localparam logic [11:0] DIV_SLOW = 12'(DIV_SLOW_I);
    localparam logic [11:0] DIV_FAST = 12'(DIV_FAST_I);

    // Dividers must fit the 12-bit bit counters and leave a usable mid-bit point
    if (DIV_SLOW_I > 4095 || DIV_FAST_I < 4 || FIFO_DEPTH < 2) begin : g_bad_setup
        $error("srcp_cmd_port: bit divider or buffer depth out of range");
    end

    function automatic logic is_query(input logic [7:0] addr);
        return (addr == `SRCP_ADDR_STATUS) || (addr == `SRCP_ADDR_TEMP) ||
               (addr == `SRCP_ADDR_CAL_MEM) || (addr == `SRCP_ADDR_USER_MEM);
    endfunction

    // Number of data bytes that belong to a register address
    function automatic logic [2:0] data_len(input logic [7:0] addr);
        unique case (addr)
            `SRCP_ADDR_STATUS:   return `SRCP_LEN_STATUS;
            `SRCP_ADDR_TEMP:     return `SRCP_LEN_TEMP;
            `SRCP_ADDR_CAL_MEM:  return `SRCP_LEN_CAL_MEM;
            `SRCP_ADDR_USER_MEM: return `SRCP_LEN_USER_MEM;
            default:             return `SRCP_LEN_CONFIG;
        endcase
    endfunction

    // ---------------- Rate strap ----------------
    logic [1:0] strap_sync;
    logic [1:0] strap_cnt;
    logic       rate_ready;
    logic [11:0] bit_div;

    always_ff @(posedge clock) begin
        strap_sync <= {strap_sync[0], rate_strap};
    end

    // Strap is caught once, three edges after release, so the synchroniser holds the pin level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strap_cnt  <= 2'h0;
            rate_ready <= 1'b0;
            fast_rate  <= 1'b0;
        end else if (!rate_ready) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `SRCP_STRAP_TAKE) begin
                rate_ready <= 1'b1;
                fast_rate  <= ~strap_sync[1];
            end
        end
    end

    assign bit_div = fast_rate ? DIV_FAST : DIV_SLOW;

    // ---------------- Receiver ----------------
    logic [1:0]  rx_sync;
    logic        rx_in;
    logic        rx_busy;
    logic [11:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic        rx_push;
    logic [7:0]  rx_byte;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_sync <= 2'b11;
        end else begin
            rx_sync <= {rx_sync[0], serial_rx};
        end
    end
    assign rx_in = rx_sync[1];

    // Bits are sampled at mid-cell; a start bit that is gone at mid-cell counts as a glitch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_busy  <= 1'b0;
            rx_cnt   <= 12'h000;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
            rx_push  <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_push <= 1'b0;
            if (!rx_busy) begin
                if (rate_ready && !rx_in) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= bit_div >> 1;
                    rx_bit  <= 4'h0;
                end
            end else if (rx_cnt != 12'h000) begin
                rx_cnt <= rx_cnt - 12'h001;
            end else begin
                rx_cnt <= bit_div - 12'h001;
                if (rx_bit == 4'h0) begin
                    if (rx_in) begin
                        rx_busy <= 1'b0;
                    end else begin
                        rx_bit <= 4'h1;
                    end
                end else if (rx_bit == `SRCP_LAST_SLOT) begin
                    // No parity slot; a low stop bit drops the character
                    rx_busy <= 1'b0;
                    if (rx_in) begin
                        rx_push <= 1'b1;
                        rx_byte <= rx_shift;
                    end
                end else begin
                    rx_shift <= {rx_in, rx_shift[7:1]};
                    rx_bit   <= rx_bit + 4'h1;
                end
            end
        end
    end

    // With no flow control a full buffer can only lose the byte; the loss is kept visible
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_overrun <= 1'b0;
        end else if (rx_push && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
        end
    end

    srcp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (rx_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ---------------- Command machine ----------------
    srcp_pkg::srcp_state_t state;
    logic [2:0]  need;
    logic        cmd_query;
    logic [15:0] tx_buf;
    logic [1:0]  tx_left;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic        tx_busy;

    // Bytes are only drained while collecting; during execution the buffer backs up
    assign fifo_out_ready = (state == srcp_pkg::SRCP_ADDR) || (state == srcp_pkg::SRCP_DATA);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state     <= srcp_pkg::SRCP_ADDR;
            need      <= 3'h0;
            cmd_query <= 1'b0;
            cmd_addr  <= 8'h00;
            cmd_data  <= 32'h0000_0000;
            cfg_req   <= 1'b0;
            qry_req   <= 1'b0;
            tx_buf    <= 16'h0000;
            tx_left   <= 2'h0;
            tx_go     <= 1'b0;
            tx_byte   <= 8'h00;
        end else begin
            cfg_req <= 1'b0;
            qry_req <= 1'b0;
            tx_go   <= 1'b0;
            unique case (state)
                srcp_pkg::SRCP_ADDR: begin
                    if (fifo_out_valid) begin
                        cmd_addr  <= fifo_out_data;
                        cmd_data  <= 32'h0000_0000;
                        cmd_query <= is_query(fifo_out_data);
                        need      <= data_len(fifo_out_data);
                        state     <= srcp_pkg::SRCP_DATA;
                    end
                end
                srcp_pkg::SRCP_DATA: begin
                    if (fifo_out_valid) begin
                        // First data byte is the most significant
                        cmd_data <= {cmd_data[23:0], fifo_out_data};
                        need     <= need - 3'h1;
                        if (need == 3'h1) begin
                            state   <= srcp_pkg::SRCP_EXEC;
                            cfg_req <= !cmd_query;
                            qry_req <= cmd_query;
                        end
                    end
                end
                srcp_pkg::SRCP_EXEC: begin
                    // No timeout: device logic that never finishes leaves the port waiting
                    if (!cmd_query && cfg_done) begin
                        tx_buf  <= {8'h00, cfg_ok ? `SRCP_ACK_OK : `SRCP_ACK_FAIL};
                        tx_left <= 2'h1;
                        state   <= srcp_pkg::SRCP_SEND;
                    end else if (cmd_query && qry_done) begin
                        // Temperature code and memory bytes go out untouched
                        tx_buf  <= qry_value;
                        tx_left <= 2'h2;
                        state   <= srcp_pkg::SRCP_SEND;
                    end
                end
                srcp_pkg::SRCP_SEND: begin
                    // tx_go guard covers the cycle before the transmitter shows busy
                    if (!tx_busy && !tx_go) begin
                        if (tx_left == 2'h0) begin
                            state <= srcp_pkg::SRCP_ADDR;
                        end else begin
                            tx_go   <= 1'b1;
                            tx_byte <= (tx_left == 2'h2) ? tx_buf[15:8] : tx_buf[7:0];
                            tx_left <= tx_left - 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------- Transmitter ----------------
    logic [11:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_shift;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serial_tx <= 1'b1;
            tx_busy   <= 1'b0;
            tx_cnt    <= 12'h000;
            tx_bit    <= 4'h0;
            tx_shift  <= 9'h1FF;
        end else if (!tx_busy) begin
            if (tx_go) begin
                serial_tx <= 1'b0;
                tx_busy   <= 1'b1;
                tx_cnt    <= bit_div - 12'h001;
                tx_bit    <= 4'h0;
                tx_shift  <= {1'b1, tx_byte};
            end
        end else if (tx_cnt != 12'h000) begin
            tx_cnt <= tx_cnt - 12'h001;
        end else begin
            tx_cnt <= bit_div - 12'h001;
            // Stop level went out at slot 8 and has now stood one bit time
            if (tx_bit == `SRCP_LAST_SLOT) begin
                tx_busy <= 1'b0;
            end else begin
                serial_tx <= tx_shift[0];
                tx_shift  <= {1'b1, tx_shift[8:1]};
                tx_bit    <= tx_bit + 4'h1;
            end
        end
    end

endmodule // srcp_cmd_port

// ==== tb/srcp_cmd_port_properties.sv ====
// Concurrent checks on the pins of the serial register command port.
`timescale 1ns/10ps
`include "srcp_defines.svh"
module srcp_cmd_port_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        serial_rx,
    input wire logic        serial_tx,
    input wire logic        rate_strap,
    input wire logic        fast_rate,
    input wire logic        rx_overrun,
    input wire logic        cfg_req,
    input wire logic        qry_req,
    input wire logic [7:0]  cmd_addr,
    input wire logic [31:0] cmd_data,
    input wire logic        cfg_done,
    input wire logic        cfg_ok,
    input wire logic        qry_done,
    input wire logic [15:0] qry_value
);
    logic [2:0] run_cnt;
    logic       wait_cfg;
    logic       wait_qry;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Saturating count of edges since reset release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end

    // A command is outstanding from its request until the matching done
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_cfg <= 1'b0;
        end else if (cfg_req) begin
            wait_cfg <= 1'b1;
        end else if (cfg_done) begin
            wait_cfg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_qry <= 1'b0;
        end else if (qry_req) begin
            wait_qry <= 1'b1;
        end else if (qry_done) begin
            wait_qry <= 1'b0;
        end
    end

    a_strap_slow: assert property ($rose(rst_n) && rate_strap |-> ##3 !fast_rate)
        else $error("slow rate not chosen with strap high");
    a_strap_fast: assert property ($rose(rst_n) && !rate_strap |-> ##3 fast_rate)
        else $error("fast rate not chosen with strap low");
    a_rate_held: assert property (run_cnt >= 3'h4 |-> $stable(fast_rate))
        else $error("line rate changed after strap sampling");
    a_req_pulse: assert property (cfg_req || qry_req |=> !cfg_req && !qry_req)
        else $error("request longer than one cycle");
    a_cmd_hold: assert property (wait_cfg || wait_qry |-> $stable(cmd_data))
        else $error("command data moved while executing");
    a_cfg_addr: assert property (cfg_req |-> !qry_req && !(cmd_addr inside {
        `SRCP_ADDR_STATUS, `SRCP_ADDR_TEMP, `SRCP_ADDR_CAL_MEM, `SRCP_ADDR_USER_MEM}))
        else $error("configuration request on a query address");
    a_qry_addr: assert property (qry_req |-> cmd_addr inside {
        `SRCP_ADDR_STATUS, `SRCP_ADDR_TEMP, `SRCP_ADDR_CAL_MEM, `SRCP_ADDR_USER_MEM})
        else $error("query request on a configuration address");
    a_tx_quiet: assert property (wait_cfg || wait_qry |-> serial_tx)
        else $error("transmit before the command finished");
    a_cfg_answer: assert property (wait_cfg && cfg_done |-> ##[1:4] $fell(serial_tx))
        else $error("no acknowledge after configuration done");
    a_qry_answer: assert property (wait_qry && qry_done |-> ##[1:4] $fell(serial_tx))
        else $error("no answer after query done");
    a_start_low: assert property ($fell(serial_tx) |-> !serial_tx [*8])
        else $error("start bit too short");
    a_overrun_stays: assert property (rx_overrun |=> rx_overrun)
        else $error("overrun flag cleared without reset");
endmodule // srcp_cmd_port_properties

// ==== tb/srcp_host_model.sv ====
// Host end of the serial line: sends and collects whole characters.
`timescale 1ns/10ps
module srcp_host_model (
    input  wire logic clock,
    input  wire logic serial_tx,
    output logic      serial_rx
);
    initial serial_rx = 1'b1;

    // Low start, eight bits LSB first, no parity, one high stop
    task automatic send_byte(input logic [7:0] b, input int div);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clock);
            serial_rx = frame[i];
            repeat (div - 1) @(negedge clock);
        end
    endtask

    // Mid-bit sampling; returns ok low on a bad start or stop
    task automatic recv_byte(output logic [7:0] b, output logic ok, input int div);
        int n;
        n = 0;
        b = 8'h00;
        ok = 1'b0;
        while (serial_tx !== 1'b0 && n < 200000) begin
            @(negedge clock);
            n++;
        end
        if (n < 200000) begin
            repeat (div / 2) @(negedge clock);
            ok = (serial_tx === 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(negedge clock);
                b[i] = serial_tx;
            end
            repeat (div) @(negedge clock);
            ok = ok && (serial_tx === 1'b1);
        end
    endtask

    task automatic quiet(input int n, output logic q);
        q = 1'b1;
        repeat (n) begin
            @(negedge clock);
            if (serial_tx !== 1'b1) begin
                q = 1'b0;
            end
        end
    endtask
endmodule // srcp_host_model

// ==== tb/srcp_cmd_port_tb.sv ====
// Self-checking bench for the serial register command port at both line rates.
`timescale 1ns/10ps
`include "srcp_defines.svh"
module srcp_cmd_port_tb;
    // Scaled clock rating keeps characters short; dividers become 32 and 16 clocks
    localparam int CLK_HZ   = 1843200;
    localparam int DIV_SLOW = CLK_HZ / `SRCP_BAUD_SLOW;
    localparam int DIV_FAST = CLK_HZ / `SRCP_BAUD_FAST;
    int          div_now;
    logic        clock;
    logic        rst_n;
    logic        serial_rx;
    logic        serial_tx;
    logic        rate_strap;
    logic        fast_rate;
    logic        rx_overrun;
    logic        cfg_req;
    logic        qry_req;
    logic [7:0]  cmd_addr;
    logic [31:0] cmd_data;
    logic        cfg_done;
    logic        cfg_ok;
    logic        qry_done;
    logic [15:0] qry_value;
    int          err_count;
    int          n_checks;

    srcp_cmd_port #(.CLK_HZ(CLK_HZ)) dut (
        .clock(clock), .rst_n(rst_n), .serial_rx(serial_rx), .serial_tx(serial_tx),
        .rate_strap(rate_strap), .fast_rate(fast_rate), .rx_overrun(rx_overrun),
        .cfg_req(cfg_req), .qry_req(qry_req), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cfg_done(cfg_done), .cfg_ok(cfg_ok), .qry_done(qry_done), .qry_value(qry_value)
    );
    srcp_host_model host (
        .clock(clock), .serial_tx(serial_tx), .serial_rx(serial_rx)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Strap stays put from release until well past the sampling edge
    task automatic do_reset(input logic strap);
        rst_n = 1'b0;
        rate_strap = strap;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask

    // Host sends the whole command, device logic answers, host reads every byte back
    task automatic run_cmd(input logic [7:0] addr, input logic [31:0] data, input int n,
                           input logic qry, input logic [15:0] val, input logic ok);
        logic [7:0] b0;
        logic [7:0] b1;
        logic       f0;
        logic       f1;
        logic       q;
        int         k;
        b1 = 8'h00;
        f1 = 1'b1;
        k = 0;
        fork
            begin
                host.send_byte(addr, div_now);
                for (int i = n - 1; i >= 0; i--) begin
                    host.send_byte(data[8*i +: 8], div_now);
                end
            end
            begin
                while ((qry ? qry_req : cfg_req) !== 1'b1 && k < 120000) begin
                    @(negedge clock);
                    k++;
                end
                check("cmd_addr", {24'h0, cmd_addr}, {24'h0, addr});
                check("cmd_data", cmd_data, data);
                repeat (3) @(negedge clock);
                if (qry) begin
                    qry_value = val;
                    qry_done = 1'b1;
                end else begin
                    // A done of the wrong kind first must not start an answer
                    qry_value = 16'hFFFF;
                    qry_done = 1'b1;
                    @(negedge clock);
                    qry_done = 1'b0;
                    repeat (3) @(negedge clock);
                    cfg_ok = ok;
                    cfg_done = 1'b1;
                end
                @(negedge clock);
                qry_done = 1'b0;
                cfg_done = 1'b0;
                qry_value = ~val;
                cfg_ok = ~ok;
            end
            begin
                host.recv_byte(b0, f0, div_now);
                if (qry) begin
                    host.recv_byte(b1, f1, div_now);
                end
            end
        join
        check("framing", {31'h0, f0 & f1}, 32'h1);
        if (qry) begin
            check("answer high", {24'h0, b0}, {24'h0, val[15:8]});
            check("answer low", {24'h0, b1}, {24'h0, val[7:0]});
        end else begin
            check("ack", {24'h0, b0}, {24'h0, ok ? `SRCP_ACK_OK : `SRCP_ACK_FAIL});
        end
        host.quiet(2 * div_now, q);
        check("no extra byte", {31'h0, q}, 32'h1);
    endtask

    // At the scaled clock rating all scenarios together stay near 9,200 cycles
    initial begin
        #250000;
        err_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        rate_strap = 1'b1;
        cfg_done = 1'b0;
        cfg_ok = 1'b0;
        qry_done = 1'b0;
        qry_value = 16'h0000;
        err_count = 0;
        n_checks = 0;
        div_now = DIV_SLOW;
        do_reset(1'b1);
        check("fast_rate", {31'h0, fast_rate}, 32'h0);
        rate_strap = 1'b0;
        repeat (8) @(negedge clock);
        check("fast_rate held", {31'h0, fast_rate}, 32'h0);
        // Strap is now low, yet the line must still run at the slow rate
        run_cmd(`SRCP_ADDR_STATUS, 32'h0000_0000, 1, 1'b1, 16'h5AC3, 1'b1);
        $display("Test strap and slow rate: done");
        div_now = DIV_FAST;
        do_reset(1'b0);
        check("fast_rate", {31'h0, fast_rate}, 32'h1);
        rate_strap = 1'b1;
        run_cmd(`SRCP_ADDR_TEMP, 32'h0000_0000, 1, 1'b1, 16'hA53C, 1'b0);
        run_cmd(`SRCP_ADDR_CAL_MEM, 32'h0000_0012, 2, 1'b1, 16'h7E81, 1'b0);
        run_cmd(`SRCP_ADDR_USER_MEM, 32'h0000_0107, 2, 1'b1, 16'h3C42, 1'b0);
        $display("Test query: done");
        run_cmd(8'h05, 32'h8001_7F00, 4, 1'b0, 16'h0000, 1'b0);
        run_cmd(8'h0A, 32'h0000_0001, 4, 1'b0, 16'h0000, 1'b1);
        $display("Test configuration: done");
        check("fast_rate kept", {31'h0, fast_rate}, 32'h1);
        check("rx_overrun", {31'h0, rx_overrun}, 32'h0);
        // Bytes behind a command that never completes back up; the seventeenth is lost
        for (int i = 0; i < 22; i++) begin
            host.send_byte(8'h05, div_now);
        end
        check("rx_overrun set", {31'h0, rx_overrun}, 32'h1);
        do_reset(1'b0);
        check("rx_overrun cleared", {31'h0, rx_overrun}, 32'h0);
        $display("Test overrun: done");
        summarize();
    end
endmodule // srcp_cmd_port_tb

bind srcp_cmd_port srcp_cmd_port_properties chk (
    .clock(clock), .rst_n(rst_n), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .rate_strap(rate_strap), .fast_rate(fast_rate), .rx_overrun(rx_overrun),
    .cfg_req(cfg_req), .qry_req(qry_req), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cfg_done(cfg_done), .cfg_ok(cfg_ok), .qry_done(qry_done), .qry_value(qry_value)
);
